// [hw/eag_pkg.sv]
// Purpose: Shared constants and types for the effective address generator
// Assumes: Big-endian bit numbering on the architecture side (bit 0 = MSB)
// Notes:   Vector index = 31 - architectural bit number
package eag_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int ADDR_W = 17;
    localparam int RSEL_W = 4;
    localparam int XSEL_W = 3;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    // Instruction field positions (vector index, LSB = arch bit 31)
    localparam int IND_POS = 31;
    localparam int RSEL_LSB = 20;
    localparam int XSEL_LSB = 17;
    localparam int ADDR_LSB = 0;
    // Index shift amounts per operand size
    localparam int SHIFT_DW = 1;
    localparam int SHIFT_HW = 1;
    localparam int SHIFT_BY = 2;
    // Private register reached by a zero effective address
    localparam logic [RSEL_W-1:0] ZERO_ADDR_REG = 4'h0;
    localparam logic [ADDR_W-1:0] ZERO_ADDR = 17'h00000;
    localparam logic [XSEL_W-1:0] NO_INDEX = 3'h0;

    // Operand size of the current reference
    typedef enum logic [1:0] {
        EAG_SZ_WORD,
        EAG_SZ_DOUBLE,
        EAG_SZ_HALF,
        EAG_SZ_BYTE
    } eag_size_t;

    // Position of a halfword or byte inside the word
    typedef logic [1:0] eag_lane_t;
endpackage

// [hw/eag_mem_if.sv]
// Purpose: Operand memory port shared by sequencer and aligner
// Assumes: One request outstanding at a time
// Notes:   Private flag steers the reference away from core memory
`timescale 1ns/10ps
interface eag_mem_if;
    // ------------------------------------------------------------
    // Returned operand path
    // ------------------------------------------------------------
    logic rvalid;
    logic [eag_pkg::WORD_W-1:0] rdata;
    logic [1:0] lane;
    eag_pkg::eag_size_t size;
    // Aligned result
    logic [eag_pkg::WORD_W-1:0] aligned;

    modport seq (
        output lane,
        output size,
        input aligned
    );
    modport align (
        input lane,
        input size,
        input rdata,
        output aligned
    );
endinterface

// [hw/eag_align.sv]
// Purpose: Operand alignment of halfwords and bytes
// Assumes: Lane and size stay stable while the word is returned
// Notes:   Purely combinational
`timescale 1ns/10ps
module eag_align (
    // Operand path
    eag_mem_if.align mp
);
    // ------------------------------------------------------------
    // Extraction
    // ------------------------------------------------------------
    logic [eag_pkg::HALF_W-1:0] half_sel;
    logic [eag_pkg::BYTE_W-1:0] byte_sel;

    // Pick halfword/byte; lane 0 is the leftmost, most significant
    always_comb begin
        half_sel = mp.lane[0] ? mp.rdata[15:0] : mp.rdata[31:16];
        unique case (mp.lane)
            2'h0: byte_sel = mp.rdata[31:24];
            2'h1: byte_sel = mp.rdata[23:16];
            2'h2: byte_sel = mp.rdata[15:8];
            default: byte_sel = mp.rdata[7:0];
        endcase
        unique case (mp.size)
            eag_pkg::EAG_SZ_HALF: begin
                // Sign copied into the upper 16 bits
                mp.aligned = {{eag_pkg::HALF_W{half_sel[15]}},
                              half_sel};
            end
            eag_pkg::EAG_SZ_BYTE: begin
                // Byte lands right-justified, rest cleared
                mp.aligned = {24'h000000, byte_sel};
            end
            default: begin
                mp.aligned = mp.rdata;
            end
        endcase
    end
endmodule

// [hw/eag_core.sv]
// Purpose: Effective address generation and operand steering
// Assumes: Memory answers each read with mem_rvalid a cycle or more later
// Notes:   Core memory and private registers sit outside this block
// How it works
// - Indirect plus index: fetch pointer, then index
// - Indexed word adds index unscaled to reference
// - Doubleword is odd word then even
// - Doubleword address LSB forced to zero
// - Doubleword index shifted left by one
// - Even register: even-even, odd-odd transfer
// - Odd register receives both words
// - Most significant word loaded last
// - Left half bits 0-15, right 16-31
// - Unindexed halfword picks left half
// - Halfword index shifted right, bit 31 selects
// - Halfword load sign-extends upper sixteen bits
// - Bytes numbered left to right
// - Unindexed byte picks leftmost byte
// - Byte index shifted right by two
// - Byte load zero-extends into low bits
// - Address zero served from private register; pointer fetch at zero reads core memory, a store there writes nothing
// - Index field zero means no indexing
// - Only one level of indirection
// - Address bits 15-31, indirect flag bit 0
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module eag_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Instruction request
    input wire logic start,
    input wire logic [eag_pkg::WORD_W-1:0] instr,
    input wire eag_pkg::eag_size_t op_size,
    input wire logic op_store,
    output logic busy,
    output logic done,
    // Index register read (combinational lookup)
    output logic [eag_pkg::XSEL_W-1:0] idx_sel,
    input wire logic [eag_pkg::WORD_W-1:0] idx_data,
    // Core memory read/write
    output logic mem_req,
    output logic mem_we,
    output logic [eag_pkg::ADDR_W-1:0] mem_addr,
    output logic [eag_pkg::WORD_W-1:0] mem_wdata,
    input wire logic mem_rvalid,
    input wire logic [eag_pkg::WORD_W-1:0] mem_rdata,
    // Private register access for address zero
    output logic preg_rd,
    input wire logic [eag_pkg::WORD_W-1:0] preg_rdata,
    // Store data from the source register
    input wire logic [eag_pkg::WORD_W-1:0] store_data,
    // Destination register write
    output logic reg_we,
    output logic [eag_pkg::RSEL_W-1:0] reg_addr,
    output logic [eag_pkg::WORD_W-1:0] reg_wdata,
    output logic [1:0] lane_sel
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_IND,
        ST_CALC,
        ST_ACC0,
        ST_WAIT0,
        ST_ACC1,
        ST_WAIT1
    } eag_state_t;

    eag_state_t state_reg, state_next;
    // Latched instruction fields
    logic [eag_pkg::ADDR_W-1:0] ref_reg, ref_next;
    logic [eag_pkg::XSEL_W-1:0] xsel_reg, xsel_next;
    logic [eag_pkg::RSEL_W-1:0] rsel_reg, rsel_next;
    eag_pkg::eag_size_t size_reg, size_next;
    logic store_reg, store_next;
    logic [eag_pkg::ADDR_W-1:0] ea_reg, ea_next;
    logic [1:0] lane_reg, lane_next;
    logic [eag_pkg::WORD_W-1:0] wdata_reg, wdata_next;
    // Output registers
    logic req_reg, req_next;
    logic we_reg, we_next;
    logic prd_reg, prd_next;
    logic rwe_reg, rwe_next;
    logic [eag_pkg::RSEL_W-1:0] raddr_reg, raddr_next;
    logic [eag_pkg::WORD_W-1:0] rdat_reg, rdat_next;
    logic done_reg, done_next;
    // Second word of a doubleword pending
    logic second;

    // Aligner link
    eag_mem_if mif ();
    assign mif.rvalid = mem_rvalid | prd_reg;
    assign mif.rdata = prd_reg ? preg_rdata : mem_rdata;
    assign mif.lane = lane_reg;
    assign mif.size = size_reg;

    eag_align u_align (
        .mp(mif)
    );

    // ------------------------------------------------------------
    // Address arithmetic
    // ------------------------------------------------------------
    // Index scaled by operand size; sum truncated to field width
    function automatic logic [eag_pkg::ADDR_W-1:0] scaled_index(
        input logic [eag_pkg::WORD_W-1:0] x,
        input eag_pkg::eag_size_t sz);
        logic [eag_pkg::WORD_W-1:0] s;
        s = x;
        unique case (sz)
            eag_pkg::EAG_SZ_DOUBLE: s = x << eag_pkg::SHIFT_DW;
            eag_pkg::EAG_SZ_HALF: s = x >> eag_pkg::SHIFT_HW;
            eag_pkg::EAG_SZ_BYTE: s = x >> eag_pkg::SHIFT_BY;
            default: s = x;
        endcase
        return s[eag_pkg::ADDR_W-1:0];
    endfunction

    // Lane selected by low index bits; lane 0 without an index
    function automatic logic [1:0] pick_lane(
        input logic [eag_pkg::WORD_W-1:0] x,
        input eag_pkg::eag_size_t sz,
        input logic indexed);
        logic [1:0] l;
        l = 2'h0;
        if (indexed && sz == eag_pkg::EAG_SZ_HALF) begin
            l = {1'b0, x[0]};
        end else if (indexed && sz == eag_pkg::EAG_SZ_BYTE) begin
            l = x[1:0];
        end
        return l;
    endfunction

    logic indexed;
    logic [eag_pkg::ADDR_W-1:0] sum;
    assign indexed = xsel_reg != eag_pkg::NO_INDEX;
    assign idx_sel = xsel_reg;
    // Carry out of the top bit is dropped
    assign sum = ref_reg + (indexed ? scaled_index(idx_data, size_reg)
                                    : eag_pkg::ZERO_ADDR);
    assign second = state_reg == ST_ACC1 || state_reg == ST_WAIT1;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        ref_next = ref_reg;
        xsel_next = xsel_reg;
        rsel_next = rsel_reg;
        size_next = size_reg;
        store_next = store_reg;
        ea_next = ea_reg;
        lane_next = lane_reg;
        wdata_next = wdata_reg;
        req_next = 1'b0;
        we_next = 1'b0;
        prd_next = 1'b0;
        rwe_next = 1'b0;
        raddr_next = raddr_reg;
        rdat_next = rdat_reg;
        done_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    // Field extraction from instruction word
                    ref_next = instr[eag_pkg::ADDR_LSB +:
                                     eag_pkg::ADDR_W];
                    xsel_next = instr[eag_pkg::XSEL_LSB +:
                                      eag_pkg::XSEL_W];
                    rsel_next = instr[eag_pkg::RSEL_LSB +:
                                      eag_pkg::RSEL_W];
                    size_next = op_size;
                    store_next = op_store;
                    if (instr[eag_pkg::IND_POS]) begin
                        // Pointer fetch through reference address
                        ea_next = instr[eag_pkg::ADDR_LSB +:
                                        eag_pkg::ADDR_W];
                        req_next = 1'b1;
                        state_next = ST_IND;
                    end else begin
                        state_next = ST_CALC;
                    end
                end
            end
            ST_IND: begin
                if (mem_rvalid) begin
                    // Pointer used as is, no further indirection
                    ref_next = mem_rdata[eag_pkg::ADDR_W-1:0];
                    state_next = ST_CALC;
                end
            end
            ST_CALC: begin
                // Post-index applied to the final virtual address
                ea_next = sum;
                if (size_reg == eag_pkg::EAG_SZ_DOUBLE) begin
                    // Pair base is even; its odd partner goes first
                    // so the most significant word is loaded last
                    ea_next[0] = 1'b1;
                end
                lane_next = pick_lane(idx_data, size_reg, indexed);
                state_next = ST_ACC0;
            end
            ST_ACC0, ST_ACC1: begin
                if (store_reg) begin
                    wdata_next = store_data;
                    we_next = ea_reg != eag_pkg::ZERO_ADDR;
                end
                // Address zero goes to the private register
                if (ea_reg == eag_pkg::ZERO_ADDR) begin
                    prd_next = 1'b1;
                end else begin
                    req_next = 1'b1;
                end
                state_next = state_reg == ST_ACC0 ? ST_WAIT0 : ST_WAIT1;
            end
            ST_WAIT0, ST_WAIT1: begin
                if (mem_rvalid || prd_reg) begin
                    rwe_next = !store_reg;
                    rdat_next = mif.aligned;
                    // Odd word to rsel|1, even to rsel; odd rsel
                    // keeps one target for both words
                    raddr_next = rsel_reg;
                    if (size_reg == eag_pkg::EAG_SZ_DOUBLE) begin
                        if (!second) begin
                            // Odd (least significant) word first so
                            // the most significant lands last
                            raddr_next = rsel_reg | 4'h1;
                            // Even base word of the pair follows
                            ea_next = ea_reg & 17'h1fffe;
                        end
                        // Even word goes to rsel itself
                    end
                    if (size_reg == eag_pkg::EAG_SZ_DOUBLE && !second) begin
                        state_next = ST_ACC1;
                    end else begin
                        done_next = 1'b1;
                        state_next = ST_IDLE;
                    end
                    if (second) begin
                        ea_next = ea_reg & 17'h1fffe;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            ref_reg <= eag_pkg::ZERO_ADDR;
            xsel_reg <= eag_pkg::NO_INDEX;
            rsel_reg <= eag_pkg::ZERO_ADDR_REG;
            size_reg <= eag_pkg::EAG_SZ_WORD;
            store_reg <= 1'b0;
            ea_reg <= eag_pkg::ZERO_ADDR;
            lane_reg <= 2'h0;
            wdata_reg <= 32'h00000000;
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            prd_reg <= 1'b0;
            rwe_reg <= 1'b0;
            raddr_reg <= eag_pkg::ZERO_ADDR_REG;
            rdat_reg <= 32'h00000000;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ref_reg <= ref_next;
            xsel_reg <= xsel_next;
            rsel_reg <= rsel_next;
            size_reg <= size_next;
            store_reg <= store_next;
            ea_reg <= ea_next;
            lane_reg <= lane_next;
            wdata_reg <= wdata_next;
            req_reg <= req_next;
            we_reg <= we_next;
            prd_reg <= prd_next;
            rwe_reg <= rwe_next;
            raddr_reg <= raddr_next;
            rdat_reg <= rdat_next;
            done_reg <= done_next;
        end
    end

    // Outputs, all registered except busy
    assign busy = state_reg != ST_IDLE;
    assign done = done_reg;
    assign mem_req = req_reg;
    assign mem_we = we_reg;
    assign mem_addr = ea_reg;
    assign mem_wdata = wdata_reg;
    assign preg_rd = prd_reg;
    assign reg_we = rwe_reg;
    assign reg_addr = raddr_reg;
    assign reg_wdata = rdat_reg;
    assign lane_sel = lane_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_ZERO_NO_CORE: assert property (@(posedge core_clk)
        disable iff (sys_rst) mem_req && state_reg != ST_IND
        |-> mem_addr != eag_pkg::ZERO_ADDR)
        else $error("core access at address zero");
    AST_DW_EVEN: assert property (@(posedge core_clk)
        disable iff (sys_rst) mem_req && state_reg == ST_WAIT1
        && size_reg == eag_pkg::EAG_SZ_DOUBLE |-> !mem_addr[0])
        else $error("doubleword base not even");
    AST_DW_PAIR: assert property (@(posedge core_clk)
        disable iff (sys_rst) state_reg == ST_ACC1
        |-> !ea_reg[0] && (ea_reg | 17'h00001) == $past(ea_reg))
        else $error("doubleword words not one even-odd pair");
    AST_LANE_HOLD: assert property (@(posedge core_clk)
        disable iff (sys_rst) state_reg == ST_WAIT0 && !mem_rvalid
        && !prd_reg |=> $stable(lane_reg))
        else $error("lane changed while waiting");
    AST_ONE_IND: assert property (@(posedge core_clk)
        disable iff (sys_rst) state_reg == ST_IND && mem_rvalid
        |=> state_reg == ST_CALC)
        else $error("second indirection");
    AST_NO_INDEX: assert property (@(posedge core_clk)
        disable iff (sys_rst) state_reg == ST_CALC && !indexed
        && size_reg != eag_pkg::EAG_SZ_DOUBLE |=> ea_reg == $past(ref_reg)
        && lane_reg == 2'h0)
        else $error("unindexed address modified");
    AST_HALF_SIGN: assert property (@(posedge core_clk)
        disable iff (sys_rst) rwe_reg && size_reg == eag_pkg::EAG_SZ_HALF
        |-> reg_wdata[31:16] == {16{reg_wdata[15]}})
        else $error("halfword not sign extended");
    AST_BYTE_ZERO: assert property (@(posedge core_clk)
        disable iff (sys_rst) rwe_reg && size_reg == eag_pkg::EAG_SZ_BYTE
        |-> reg_wdata[31:8] == 24'h000000)
        else $error("byte upper bits not cleared");
    AST_MSW_LAST: assert property (@(posedge core_clk)
        disable iff (sys_rst) rwe_reg && done_reg
        && size_reg == eag_pkg::EAG_SZ_DOUBLE |-> reg_addr == rsel_reg)
        else $error("doubleword final write not to selected register");
endmodule

// [bench/eag_mem_model.sv]
// Purpose: Far-side model: index registers, core memory, private register
// Assumes: One core memory request outstanding at a time
// Notes:   Read data show an inverted word outside their valid cycle
`timescale 1ns/10ps
module eag_mem_model (
    // Clock, reset and pacing
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic slow,
    // Index register file
    input wire logic [7:0][31:0] idx_file,
    input wire logic [2:0] idx_sel,
    output logic [31:0] idx_data,
    // Core memory
    input wire logic mem_req,
    input wire logic [16:0] mem_addr,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata,
    // Private register at address zero
    input wire logic preg_rd,
    output logic [31:0] preg_rdata
);
    localparam logic [31:0] PREG_WORD = 32'h8f1e2d3c; // Arbitrary contents
    logic pend; // Request waiting for its answer
    logic [2:0] wait_cnt; // Extra cycles before answering
    logic [16:0] addr_q; // Address of the pending access

    // Memory contents are a fixed scramble of the address
    function automatic logic [31:0] mem_word(input logic [16:0] a);
        return {a[15:0] ^ 16'hc3a5, a[16:1] ^ 16'h5a96};
    endfunction

    // Index registers answer in the same cycle
    assign idx_data = idx_file[idx_sel];
    // Never show stale data: a simulator would pick 0 or 1 for unknowns
    assign mem_rdata = mem_rvalid ? mem_word(addr_q) : ~mem_word(addr_q);
    assign preg_rdata = preg_rd ? PREG_WORD : ~PREG_WORD;

    // Answer each request after one cycle, or several when slow
    always @(posedge core_clk) begin
        mem_rvalid <= 1'b0;
        if (sys_rst) begin
            pend <= 1'b0;
        end else if (mem_req) begin
            pend <= 1'b1;
            addr_q <= mem_addr;
            wait_cnt <= slow ? 3'($urandom_range(1, 6)) : 3'h0;
        end else if (pend && wait_cnt == 3'h0) begin
            pend <= 1'b0;
            mem_rvalid <= 1'b1;
        end else if (pend) begin
            wait_cnt <= wait_cnt - 3'h1;
        end
    end
endmodule

// [bench/effective_address_generator_test.sv]
// Purpose: Self-checking bench for the effective address generator
// Assumes: Far-side model answers reads after one cycle, or after a random delay when slow
// Notes:   Fixed corner cases first, then a random mix from seed 12
`timescale 1ns/10ps
module effective_address_generator_test;
    localparam logic [31:0] PREG_WORD = 32'h8f1e2d3c; // Same as the model
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic [31:0] instr = 32'h0;
    eag_pkg::eag_size_t op_size = eag_pkg::EAG_SZ_WORD;
    logic op_store = 1'b0;
    logic [31:0] store_data = 32'h0;
    logic slow = 1'b0;
    logic [7:0][31:0] idx_file = '0;
    logic busy, done, mem_req, mem_we, mem_rvalid, preg_rd, reg_we;
    logic [2:0] idx_sel;
    logic [31:0] idx_data, mem_wdata, mem_rdata, preg_rdata, reg_wdata;
    logic [16:0] mem_addr;
    logic [3:0] reg_addr;
    logic [1:0] lane_sel;
    logic [31:0] regs [16]; // Shadow of the destination registers
    logic [16:0] acc_a [$]; // Core memory addresses in order
    logic [31:0] acc_d [$]; // Write data per access
    logic acc_w [$]; // Write flag per access
    int n_preg; // Private register reads
    int n_errors = 0;
    int tests_run = 0;

    always #2.5 core_clk = ~core_clk;

    eag_core i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .start(start),
        .instr(instr), .op_size(op_size), .op_store(op_store), .busy(busy),
        .done(done), .idx_sel(idx_sel), .idx_data(idx_data),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .preg_rd(preg_rd), .preg_rdata(preg_rdata),
        .store_data(store_data), .reg_we(reg_we), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .lane_sel(lane_sel));

    eag_mem_model i_mem (.core_clk(core_clk), .sys_rst(sys_rst),
        .slow(slow), .idx_file(idx_file), .idx_sel(idx_sel),
        .idx_data(idx_data), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .preg_rd(preg_rd),
        .preg_rdata(preg_rdata));

    // Log every access and register write the block makes
    always @(posedge core_clk) begin
        if (mem_req) begin
            acc_a.push_back(mem_addr);
            acc_d.push_back(mem_wdata);
            acc_w.push_back(mem_we);
        end
        if (preg_rd) n_preg++;
        if (reg_we) regs[reg_addr] <= reg_wdata;
    end

    // Print counts and verdict, then stop
    task automatic end_sim();
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Expected memory contents, independent of the model's copy
    function automatic logic [31:0] ref_word(input logic [16:0] a);
        return {a[15:0] ^ 16'hc3a5, a[16:1] ^ 16'h5a96};
    endfunction

    function automatic logic [31:0] mk(input logic ind, input logic [3:0] rs,
                                       input logic [2:0] xs, input int ra);
        return {ind, 7'h0, rs, xs, 17'(ra)};
    endfunction

    // Issue one instruction, wait for done, compare against the rules
    task automatic run_op(input logic [31:0] ins, input eag_pkg::eag_size_t sz,
                          input logic st);
        logic [16:0] ra, off, ea;
        logic [31:0] x, w, e;
        logic [3:0] rs;
        logic [1:0] ln;
        logic dbl, pz;
        int n, k;
        ra = ins[16:0];
        rs = ins[23:20];
        dbl = (sz == eag_pkg::EAG_SZ_DOUBLE);
        x = (ins[19:17] != 3'h0) ? idx_file[ins[19:17]] : 32'h0;
        w = ref_word(ra);
        case (sz)
            eag_pkg::EAG_SZ_DOUBLE: off = {x[15:0], 1'b0};
            eag_pkg::EAG_SZ_HALF: off = x[17:1];
            eag_pkg::EAG_SZ_BYTE: off = x[18:2];
            default: off = x[16:0];
        endcase
        ln = (sz == eag_pkg::EAG_SZ_HALF) ? {1'b0, x[0]} :
             (sz == eag_pkg::EAG_SZ_BYTE) ? x[1:0] : 2'h0;
        ea = (ins[31] ? w[16:0] : ra) + off;
        if (dbl) ea[0] = 1'b0;
        pz = (ea == 17'h0) && !dbl;
        w = pz ? PREG_WORD : ref_word(ea);
        e = w;
        if (sz == eag_pkg::EAG_SZ_HALF) begin
            e = ln[0] ? {{16{w[15]}}, w[15:0]} : {{16{w[31]}}, w[31:16]};
        end else if (sz == eag_pkg::EAG_SZ_BYTE) begin
            e = {24'h0, 8'(w >> (8 * (3 - ln)))};
        end
        acc_a.delete();
        acc_d.delete();
        acc_w.delete();
        n_preg = 0;
        foreach (regs[i]) regs[i] = 32'h0;
        @(posedge core_clk);
        start <= 1'b1;
        instr <= ins;
        op_size <= sz;
        op_store <= st;
        store_data <= $urandom;
        @(posedge core_clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        check(32'(n < 60), 32'h1);
        check({31'h0, busy}, 32'h0);
        n = (ins[31] ? 1 : 0) + (pz ? 0 : (dbl ? 2 : 1));
        check(32'(acc_a.size()), 32'(n));
        if (ins[31] && acc_a.size() > 0) check(32'(acc_a[0]), 32'(ra));
        if (pz) check(32'(n_preg), 32'h1);
        k = acc_a.size() - 1;
        if (st) begin
            if (!pz && k >= 0) begin
                check({acc_w[k], 14'h0, acc_a[k]}, {1'b1, 14'h0, ea});
                check(acc_d[k], store_data);
            end
        end else if (dbl && k > 0) begin
            check({acc_a[k-1][16:1], acc_a[k][16:1]}, {ea[16:1], ea[16:1]});
            check(32'({acc_a[k-1][0], acc_a[k][0]}), 32'h2);
            check(regs[rs], ref_word(ea));
            if (!rs[0]) check(regs[rs | 4'h1], ref_word(ea | 17'h1));
        end else if (!dbl) begin
            check(regs[rs], e);
            if (!pz && k >= 0) check(32'(acc_a[k]), 32'(ea));
            if (sz != eag_pkg::EAG_SZ_WORD) check(32'(lane_sel), 32'(ln));
        end
    endtask

    // Corner cases, then a random mix
    initial begin
        void'($urandom(12));
        idx_file[0] = 32'h1234;
        idx_file[3] = 32'h213;
        idx_file[5] = 32'h44e6;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        run_op(mk(1, 9, 3, 'h5b6), eag_pkg::EAG_SZ_WORD, 1'b1);
        run_op(mk(0, 12, 5, 'h407), eag_pkg::EAG_SZ_WORD, 1'b0);
        run_op(mk(0, 12, 0, 'h100), eag_pkg::EAG_SZ_WORD, 1'b0);
        idx_file[2] = 32'h3;
        run_op(mk(0, 1, 2, 'h1ffff), eag_pkg::EAG_SZ_WORD, 1'b0);
        idx_file[5] = 32'h5;
        run_op(mk(0, 2, 5, 'h713), eag_pkg::EAG_SZ_DOUBLE, 1'b0);
        run_op(mk(0, 3, 5, 'h713), eag_pkg::EAG_SZ_DOUBLE, 1'b0);
        run_op(mk(0, 15, 0, 'h63b), eag_pkg::EAG_SZ_HALF, 1'b0);
        idx_file[5] = 32'h1;
        run_op(mk(0, 15, 5, 'h63b), eag_pkg::EAG_SZ_HALF, 1'b0);
        idx_file[5] = 32'h603;
        run_op(mk(0, 15, 5, 'h33a), eag_pkg::EAG_SZ_HALF, 1'b0);
        run_op(mk(0, 0, 0, 'h4037), eag_pkg::EAG_SZ_BYTE, 1'b0);
        for (int l = 0; l < 4; l++) begin
            idx_file[4] = 32'(l);
            run_op(mk(0, 10, 4, 'h4037), eag_pkg::EAG_SZ_BYTE, 1'b0);
        end
        idx_file[5] = 32'h3;
        run_op(mk(0, 10, 5, 0), eag_pkg::EAG_SZ_BYTE, 1'b0);
        idx_file[6] = 32'h40;
        run_op(mk(0, 5, 6, 'h4037), eag_pkg::EAG_SZ_BYTE, 1'b0);
        for (int i = 0; i < 40; i++) begin
            for (int r = 1; r < 8; r++) idx_file[r] = $urandom_range(0, 511);
            slow = 1'($urandom_range(0, 1));
            op_size <= eag_pkg::eag_size_t'($urandom_range(0, 3));
            @(posedge core_clk);
            run_op(mk(1'($urandom_range(0, 1)), 4'($urandom_range(0, 15)),
                      3'($urandom_range(0, 7)), $urandom_range(1, 131071)),
                   op_size, op_size == eag_pkg::EAG_SZ_WORD && i[0]);
        end
        end_sim();
    end

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        end_sim();
    end
endmodule
